//--- shared/aen_pkg.sv
package aen_pkg;

	// Clock and packet geometry
	localparam int CLK_PERIOD_NS  = 10;
	localparam int BYTE_W         = 8;
	localparam int WORD_W         = 32;
	localparam int HDR_W          = 128;
	localparam int CNT_W          = 32;

	// Driver lead before first data, in clocks
	localparam int PREP_CLKS      = 2;

	// Command response limit
	localparam int RESP_TIME_MS   = 50;
	localparam int RESP_CYC       = RESP_TIME_MS * 1_000_000 / CLK_PERIOD_NS;

	// Power-up and asynchronous reset blackout limit
	localparam int     READY_TIME_S = 2;
	localparam longint READY_CYC_L  = longint'(READY_TIME_S) * 64'd1_000_000_000 / longint'(CLK_PERIOD_NS);
	localparam int     READY_CYC    = int'(READY_CYC_L);

	// Event type codes
	localparam logic [7:0] TYPE_LINK = 8'h00;
	localparam logic [7:0] TYPE_CFG  = 8'h01;
	localparam logic [7:0] TYPE_DRV  = 8'h02;

	// Word positions within a packet
	localparam logic [2:0] WI_FIRST  = 3'h0;
	localparam logic [2:0] WI_TYPE   = 3'h4;
	localparam logic [2:0] WI_PAY0   = 3'h5;
	localparam logic [2:0] WI_PAY1   = 3'h6;
	localparam logic [2:0] LAST_LINK = 3'h7;
	localparam logic [2:0] LAST_CFG  = 3'h5;
	localparam logic [2:0] LAST_DRV  = 3'h6;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// Driver status word field
	localparam int DRV_RUN_BIT = 0;

	typedef enum logic [1:0] {KIND_LINK, KIND_CFG, KIND_DRV} aen_kind_type;
	typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_SEND} aen_state_type;

	typedef struct packed {
		logic                link_chg;
		logic [WORD_W-1:0]   link_status;
		logic [WORD_W-1:0]   vendor_status;
		logic                init_enter;
		logic                init_by_rst_cmd;
		logic                drv_chg;
		logic                drv_running;
	} aen_evt_type;

endpackage : aen_pkg

//--- verilog/aen_csum.sv
module aen_csum (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clr,
	input  wire logic        add,
	input  wire logic [31:0] word,
	output logic      [31:0] csum
);

	logic [31:0] sum_q;
	logic [31:0] sum_d;

	// Sum of both 16-bit halves, negated
	assign sum_d = sum_q + {16'h0000, word[31:16]} + {16'h0000, word[15:0]};
	assign csum  = ~sum_q + 32'h0000_0001;

	always_ff @(posedge mclk) begin
		if (rst || clr) begin
			sum_q <= 32'h0000_0000;
		end else if (add) begin
			sum_q <= sum_d;
		end
	end

endmodule : aen_csum

//--- verilog/sideband_aen_framer.sv
// Function
// - Link mode change queues link event packet
// - Link packet: type 0x00, status, vendor, checksum
// - Status words share query response layout
// - Initial state entry queues config event, unless reset command
// - Config packet: type 0x01 then checksum
// - Driver packet: type 0x02, status, checksum
// - Driver word bit0 running, rest zero
// - Drivers released soon after deselect response
// - Drivers enabled two clocks before data
// - Response must start within 50 ms
// - Commands ignored during async reset blackout
module sideband_aen_framer #(
	parameter int RESP_CYC     = aen_pkg::RESP_CYC,
	parameter int BLACKOUT_CYC = aen_pkg::READY_CYC
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire aen_pkg::aen_evt_type evt,
	input  wire logic [127:0]         hdr,
	input  wire logic                 deselect_done,
	input  wire logic                 select,
	input  wire logic                 arst_event,
	input  wire logic                 cmd_done,
	input  wire logic                 resp_start,
	input  wire logic                 tx_ready,
	output logic      [7:0]           tx_data,
	output logic                      tx_valid,
	output logic                      tx_last,
	output logic                      tx_oe,
	output logic                      cmd_ready,
	output logic                      resp_late
);

	aen_pkg::aen_state_type state_q, state_d;
	aen_pkg::aen_kind_type  kind_q, pick;
	logic [2:0]  pend_q, pend_d, set_vec, clr_vec, requeue;
	logic [2:0]  cur_idx_q, nxt_idx, last_w;
	logic [1:0]  bidx_q, prep_q;
	logic [31:0] word_q, word_new, csum, pay_a_q, pay_b_q, blk_q, resp_cnt_q;
	logic        desel_q, ready_prev_q, resp_wait_q, resp_late_q;
	logic        fire, word_end, is_last, pkt_end, prep_done, load, abort, start;
	logic        ready, ready_rise, cfg_evt, cmd_taken;

	function automatic logic [2:0] last_idx(input aen_pkg::aen_kind_type k);
		if (k == aen_pkg::KIND_LINK) last_idx = aen_pkg::LAST_LINK;
		else if (k == aen_pkg::KIND_CFG) last_idx = aen_pkg::LAST_CFG;
		else last_idx = aen_pkg::LAST_DRV;
	endfunction : last_idx

	function automatic logic [7:0] type_code(input aen_pkg::aen_kind_type k);
		if (k == aen_pkg::KIND_LINK) type_code = aen_pkg::TYPE_LINK;
		else if (k == aen_pkg::KIND_CFG) type_code = aen_pkg::TYPE_CFG;
		else type_code = aen_pkg::TYPE_DRV;
	endfunction : type_code

	function automatic logic [2:0] kind_bit(input aen_pkg::aen_kind_type k);
		kind_bit = 3'h1 << k;
	endfunction : kind_bit

	// Word of the packet at a given position
	function automatic logic [31:0] word_of(input logic [2:0] idx, input aen_pkg::aen_kind_type k,
	                                        input logic [127:0] h, input logic [31:0] a, input logic [31:0] b);
		if (idx < aen_pkg::WI_TYPE) word_of = h[127 - 32*idx -: 32];
		else if (idx == aen_pkg::WI_TYPE) word_of = {24'h00_0000, type_code(k)};
		else if (idx == aen_pkg::WI_PAY0) word_of = a;
		else word_of = b;
	endfunction : word_of

	// Handshake and sequencing terms
	assign fire      = tx_valid && tx_ready;
	assign word_end  = fire && (bidx_q == aen_pkg::LAST_BYTE);
	assign last_w    = last_idx(kind_q);
	assign is_last   = (cur_idx_q == last_w);
	assign pkt_end   = word_end && is_last;
	assign prep_done = (state_q == aen_pkg::ST_PREP) && (prep_q == 2'(aen_pkg::PREP_CLKS - 1));
	assign nxt_idx   = prep_done ? aen_pkg::WI_FIRST : 3'(cur_idx_q + 3'h1);
	assign load      = prep_done || (word_end && !is_last);
	assign word_new  = (nxt_idx == last_w) ? csum : word_of(nxt_idx, kind_q, hdr, pay_a_q, pay_b_q);
	assign abort     = deselect_done || arst_event;
	assign ready     = (blk_q == 32'h0000_0000);
	assign ready_rise = ready && !ready_prev_q;
	assign cfg_evt   = (evt.init_enter && !evt.init_by_rst_cmd) || ready_rise;
	assign start     = (state_q == aen_pkg::ST_IDLE) && ready && !desel_q && (|pend_q) && !abort;
	assign pick      = pend_q[aen_pkg::KIND_LINK] ? aen_pkg::KIND_LINK :
	                   pend_q[aen_pkg::KIND_CFG] ? aen_pkg::KIND_CFG : aen_pkg::KIND_DRV;
	assign cmd_taken = cmd_done && ready;

	// Pending events; a new event wins over its own clear
	assign set_vec = {evt.drv_chg, cfg_evt, evt.link_chg};
	assign clr_vec = start ? kind_bit(pick) : 3'h0;
	assign requeue = (abort && state_q != aen_pkg::ST_IDLE) ? kind_bit(kind_q) : 3'h0;
	assign pend_d  = (pend_q & ~clr_vec) | set_vec | requeue;

	// Outputs
	assign tx_data   = word_q[31:24];
	assign tx_valid  = (state_q == aen_pkg::ST_SEND);
	assign tx_last   = tx_valid && is_last && (bidx_q == aen_pkg::LAST_BYTE);
	assign cmd_ready = ready;
	assign resp_late = resp_late_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			aen_pkg::ST_IDLE: begin
				if (start) state_d = aen_pkg::ST_PREP;
			end
			aen_pkg::ST_PREP: begin
				if (abort) state_d = aen_pkg::ST_IDLE;
				else if (prep_done) state_d = aen_pkg::ST_SEND;
			end
			aen_pkg::ST_SEND: begin
				if (abort || pkt_end) state_d = aen_pkg::ST_IDLE;
			end
			default: state_d = aen_pkg::ST_IDLE;
		endcase
	end

	aen_csum u_csum (
		.mclk (mclk),
		.rst  (rst),
		.clr  (start),
		.add  (load && (nxt_idx != last_w)),
		.word (word_new),
		.csum (csum)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= aen_pkg::ST_IDLE;
			pend_q  <= 3'h0;
			tx_oe   <= 1'b0;
		end else begin
			state_q <= state_d;
			pend_q  <= pend_d;
			tx_oe   <= (start || tx_oe) && !abort && !pkt_end;
		end
	end

	// Packet contents
	always_ff @(posedge mclk) begin
		if (rst) begin
			kind_q    <= aen_pkg::KIND_LINK;
			pay_a_q   <= 32'h0000_0000;
			pay_b_q   <= 32'h0000_0000;
			prep_q    <= 2'h0;
		end else if (start) begin
			kind_q    <= pick;
			prep_q    <= 2'h0;
			if (pick == aen_pkg::KIND_DRV) begin
				pay_a_q <= 32'(evt.drv_running) << aen_pkg::DRV_RUN_BIT;
			end else begin
				pay_a_q <= evt.link_status;
			end
			pay_b_q   <= evt.vendor_status;
		end else if (state_q == aen_pkg::ST_PREP) begin
			prep_q    <= 2'(prep_q + 2'h1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			word_q    <= 32'h0000_0000;
			cur_idx_q <= 3'h0;
			bidx_q    <= 2'h0;
		end else if (load) begin
			word_q    <= word_new;
			cur_idx_q <= nxt_idx;
			bidx_q    <= 2'h0;
		end else if (fire) begin
			word_q    <= {word_q[23:0], 8'h00};
			bidx_q    <= 2'(bidx_q + 2'h1);
		end
	end

	// Deselect and blackout
	always_ff @(posedge mclk) begin
		if (rst) begin
			desel_q      <= 1'b0;
			blk_q        <= 32'(BLACKOUT_CYC);
			ready_prev_q <= 1'b0;
		end else begin
			desel_q      <= deselect_done || (desel_q && !select);
			blk_q        <= arst_event ? 32'(BLACKOUT_CYC) : (ready ? blk_q : 32'(blk_q - 32'h0000_0001));
			ready_prev_q <= ready;
		end
	end

	// Response latency watch
	always_ff @(posedge mclk) begin
		if (rst) begin
			resp_wait_q <= 1'b0;
			resp_cnt_q  <= 32'h0000_0000;
			resp_late_q <= 1'b0;
		end else if (cmd_taken) begin
			resp_wait_q <= 1'b1;
			resp_cnt_q  <= 32'h0000_0000;
			resp_late_q <= 1'b0;
		end else if (resp_start) begin
			resp_wait_q <= 1'b0;
		end else if (resp_wait_q) begin
			resp_cnt_q  <= 32'(resp_cnt_q + 32'h0000_0001);
			resp_late_q <= resp_late_q || (resp_cnt_q == 32'(RESP_CYC - 1));
		end
	end

	// Checker helper: sum of sent 16-bit words, checksum bytes kept apart
	logic [31:0] chk_acc_q;
	logic [7:0]  chk_hi_q;
	logic [23:0] chk_cs_q;
	always_ff @(posedge mclk) begin
		if (rst || start) begin
			chk_acc_q <= 32'h0000_0000;
			chk_hi_q  <= 8'h00;
			chk_cs_q  <= 24'h00_0000;
		end else if (fire && is_last) begin
			chk_cs_q  <= {chk_cs_q[15:0], tx_data};
		end else if (fire && !bidx_q[0]) begin
			chk_hi_q  <= tx_data;
		end else if (fire) begin
			chk_acc_q <= 32'(chk_acc_q + {16'h0000, chk_hi_q, tx_data});
		end
	end

	AST_LINK_PEND: assert property (@(posedge mclk) disable iff (rst)
		evt.link_chg |=> pend_q[aen_pkg::KIND_LINK] || state_q == aen_pkg::ST_PREP)
		else $error("link change not queued");
	AST_TYPE_WORD: assert property (@(posedge mclk) disable iff (rst)
		(load && nxt_idx == aen_pkg::WI_TYPE) |=> word_q == {24'h00_0000, type_code(kind_q)})
		else $error("wrong event type word");
	AST_CFG_SUPPRESS: assert property (@(posedge mclk) disable iff (rst)
		(evt.init_enter && evt.init_by_rst_cmd && !ready_rise && !pend_q[aen_pkg::KIND_CFG]
		 && !requeue[aen_pkg::KIND_CFG]) |=> !pend_q[aen_pkg::KIND_CFG])
		else $error("config event after reset command");
	AST_DRV_WORD: assert property (@(posedge mclk) disable iff (rst)
		(load && nxt_idx == aen_pkg::WI_PAY0 && kind_q == aen_pkg::KIND_DRV) |=> word_q[31:1] == 31'h0)
		else $error("driver word reserved bits set");
	AST_DESEL_HIZ: assert property (@(posedge mclk) disable iff (rst)
		deselect_done |=> !tx_oe ##1 !tx_valid)
		else $error("drivers kept after deselect");
	AST_LEAD: assert property (@(posedge mclk) disable iff (rst)
		$rose(tx_valid) |-> $past(tx_oe, 2) && $past(tx_oe))
		else $error("data without driver lead");
	AST_BLACKOUT: assert property (@(posedge mclk) disable iff (rst)
		(!cmd_ready && !arst_event) |=> blk_q == $past(blk_q) - 32'h0000_0001)
		else $error("blackout not counting down");
	AST_RESP_LATE: assert property (@(posedge mclk) disable iff (rst)
		(resp_wait_q && !cmd_taken && !resp_start && resp_cnt_q == 32'(RESP_CYC - 1)) |=> resp_late)
		else $error("late response not flagged");
	AST_CSUM: assert property (@(posedge mclk) disable iff (rst)
		(fire && tx_last) |-> 32'(chk_acc_q + {chk_cs_q, tx_data}) == 32'h0000_0000)
		else $error("checksum does not cancel");

	COV_LINK: cover property (@(posedge mclk) disable iff (rst) fire && tx_last && kind_q == aen_pkg::KIND_LINK);
	COV_CFG:  cover property (@(posedge mclk) disable iff (rst) fire && tx_last && kind_q == aen_pkg::KIND_CFG);
	COV_DRV:  cover property (@(posedge mclk) disable iff (rst) fire && tx_last && kind_q == aen_pkg::KIND_DRV);
	COV_LATE: cover property (@(posedge mclk) disable iff (rst) $rose(resp_late));

endmodule : sideband_aen_framer

//--- tb/mc_model.sv
module mc_model (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic slow,
	output logic      tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] stall_q;
	// Byte sink, stalls three cycles of four when slow
	always_ff @(posedge mclk) begin
		stall_q  <= rst ? 2'h0 : stall_q + 2'h1;
		tx_ready <= !rst && (!slow || stall_q == 2'h3);
	end
endmodule : mc_model

//--- tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RCYC = 50;
	localparam int BCYC = 20;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic [7:0]           pls = 8'h00;
	logic [31:0]          ls = 32'h0;
	logic [31:0]          vs = 32'h0;
	logic                 by_rst = 1'b0;
	logic                 run = 1'b0;
	logic                 slow = 1'b0;
	logic [127:0]         hdr = 128'h0;
	aen_pkg::aen_evt_type evt;
	logic                 tx_ready, tx_valid, tx_last, tx_oe, cmd_ready, resp_late;
	logic [7:0]           tx_data;
	logic [8:0]           exp_q[$];
	logic [8:0]           exp_b;
	int                   mismatches = 0;
	int                   compares = 0;
	int                   oe_cnt = 0;
	int                   seed = 32'hb496_7df6;
	// Pulses: link, init, drv, deselect, select, arst, cmd, resp
	assign evt = '{link_chg: pls[0], link_status: ls, vendor_status: vs, init_enter: pls[1],
		init_by_rst_cmd: by_rst, drv_chg: pls[2], drv_running: run};
	sideband_aen_framer #(.RESP_CYC(RCYC), .BLACKOUT_CYC(BCYC)) dut_u (
		.mclk(mclk), .rst(rst), .evt(evt), .hdr(hdr), .deselect_done(pls[3]), .select(pls[4]),
		.arst_event(pls[5]), .cmd_done(pls[6]), .resp_start(pls[7]), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_oe(tx_oe),
		.cmd_ready(cmd_ready), .resp_late(resp_late));
	mc_model mc_u (.mclk(mclk), .rst(rst), .slow(slow), .tx_ready(tx_ready));
	always #(aen_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
	task test_done;
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : check
	task flag(input int n, input logic late, input logic exp);
		repeat (n) @(negedge mclk);
		check({31'h0, late ? resp_late : cmd_ready}, {31'h0, exp});
	endtask : flag
	task oe_low(input int n);
		repeat (n) @(negedge mclk);
		check({31'h0, tx_oe}, 32'h0);
	endtask : oe_low
	task pulse(input logic [7:0] m);
		@(posedge mclk);
		pls <= m;
		@(posedge mclk);
		pls <= 8'h00;
	endtask : pulse
	task push_pkt(input logic [7:0] ty, input int n, input logic [31:0] p0, input logic [31:0] p1);
		logic [31:0] w[8];
		logic [31:0] sum;
		sum = 32'h0;
		for (int i = 0; i < 4; i++) w[i] = hdr[127 - 32 * i -: 32];
		w[4] = {24'h0, ty};
		w[5] = p0;
		w[6] = p1;
		for (int i = 0; i < n - 1; i++) sum += w[i][31:16] + w[i][15:0];
		w[n - 1] = -sum;
		for (int i = 0; i < 4 * n; i++) exp_q.push_back({i == 4 * n - 1, w[i / 4][31 - 8 * (i % 4) -: 8]});
	endtask : push_pkt
	task send_link(input logic [31:0] a, input logic [31:0] b);
		@(posedge mclk);
		ls <= a;
		vs <= b;
		push_pkt(aen_pkg::TYPE_LINK, 8, a, b);
		pulse(8'h01);
	endtask : send_link
	task wait_idle;
		int k;
		k = 0;
		while ((exp_q.size() > 0 || tx_oe !== 1'b0) && k < 2000) begin
			@(posedge mclk);
			k++;
		end
		check(32'(exp_q.size()) | {31'h0, k >= 2000}, 32'h0);
		repeat (3) @(posedge mclk);
	endtask : wait_idle
	// Byte watcher and driver lead check
	always @(posedge mclk) begin
		oe_cnt <= (tx_oe === 1'b1) ? oe_cnt + 1 : 0;
		if (!rst && tx_valid === 1'b1)
			check(oe_cnt >= aen_pkg::PREP_CLKS, 32'h1);
		if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : ~{tx_last, tx_data};
			check({tx_last, tx_data}, exp_b);
		end
	end
	initial begin
		#300_000;
		mismatches++;
		test_done();
	end
	initial begin
		hdr = {$random(seed), $random(seed), $random(seed), $random(seed)};
		push_pkt(aen_pkg::TYPE_CFG, 6, 32'h0, 32'h0);
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		flag(BCYC - 2, 1'b0, 1'b0);
		flag(4, 1'b0, 1'b1);
		wait_idle();
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			send_link($random(seed), $random(seed));
			wait_idle();
			@(posedge mclk);
			run <= i[1];
			push_pkt(aen_pkg::TYPE_DRV, 7, {31'h0, i[1]}, 32'h0);
			pulse(8'h04);
			wait_idle();
		end
		push_pkt(aen_pkg::TYPE_LINK, 8, ls, vs);
		push_pkt(aen_pkg::TYPE_DRV, 7, {31'h0, run}, 32'h0);
		pulse(8'h05);
		wait_idle();
		@(posedge mclk);
		by_rst <= 1'b1;
		pulse(8'h02);
		oe_low(30);
		@(posedge mclk);
		by_rst <= 1'b0;
		push_pkt(aen_pkg::TYPE_CFG, 6, 32'h0, 32'h0);
		pulse(8'h02);
		wait_idle();
		slow <= 1'b1;
		send_link($random(seed), $random(seed));
		repeat (12) @(posedge mclk);
		pulse(8'h08);
		oe_low(2);
		exp_q.delete();
		push_pkt(aen_pkg::TYPE_LINK, 8, ls, vs);
		oe_low(10);
		pulse(8'h10);
		wait_idle();
		slow <= 1'b0;
		pulse(8'h20);
		push_pkt(aen_pkg::TYPE_CFG, 6, 32'h0, 32'h0);
		flag(1, 1'b0, 1'b0);
		pulse(8'h40);
		wait_idle();
		flag(RCYC + 5, 1'b1, 1'b0);
		pulse(8'h40);
		repeat (RCYC - 5) @(posedge mclk);
		pulse(8'h80);
		flag(RCYC + 5, 1'b1, 1'b0);
		pulse(8'h40);
		flag(RCYC - 3, 1'b1, 1'b0);
		flag(8, 1'b1, 1'b1);
		pulse(8'h40);
		flag(2, 1'b1, 1'b0);
		pulse(8'h80);
		test_done();
	end
endmodule : testbench
